/* File: csp_top.sv */
// Clock source select, reset delay and system clock prescaler
//
// What this block does
// - Select code 0011 picks the 128kHz oscillator.
// - 128kHz: wake 6 clocks, reset 14+0/4/64ms.
// - Select code 0000 runs from external clock.
// - External: wake 6 clocks, reset 14+0/4.1/65ms.
// - Timer oscillator only with calibrated RC.
// - Enable bit lets timer pin take clock.
// - Output fuse drives clock on its pin.
// - Clock output continues during reset delay.
// - Clock pin carries the divided clock.
// - Divider slows CPU, I/O and flash.
// - No glitch or short period on change.
// - Divider counts source clock, count unreadable.
// - New rate active after T1+T2 to T1+2T2.
// - Unlock write is exactly 0x80.
// - Division write accepted within four cycles.
// - Software masks interrupts during the sequence.
// - Enable set only alone, four-cycle timeout.
// - Codes 0..8 give factors 1..256.
// - Reset code from divide-by-eight fuse.
`timescale 1ns/1ns
module csp_top
    import csp_pkg::*;
#(
    parameter int unsigned DLY_W       = 21,
    parameter int unsigned LFO_FAST_CY = LFO_FAST_US * CLK_MHZ,
    parameter int unsigned LFO_SLOW_CY = LFO_SLOW_US * CLK_MHZ,
    parameter int unsigned EXT_FAST_CY = EXT_FAST_US * CLK_MHZ,
    parameter int unsigned EXT_SLOW_CY = EXT_SLOW_US * CLK_MHZ
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // APB slave
    input  wire logic [11:0]  paddr,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    // Static fuses
    input  wire csp_fuse_type fuses,
    // Sleep request, high while powered down
    input  wire logic         power_down,
    // Normal port function of the clock output pin
    input  wire logic         io_pin_data,
    input  wire logic         io_pin_oe_n,
    // Clock output pin
    output logic              clock_output_pin,
    output logic              clock_output_pin_oe_n,
    // Divided system clock and core reset
    output logic              sys_clk_tick,
    output logic              core_reset_n,
    // Source and timer oscillator status
    output logic              source_is_lfo,
    output logic              source_is_ext,
    output logic              source_invalid,
    output logic              timer_osc_usable,
    output logic              timer_osc_pin_a_ext_mode
);
    // Longest reset delay over both source families
    localparam int unsigned DLY_MAX = RST_CK
        + ((LFO_SLOW_CY > EXT_SLOW_CY) ? LFO_SLOW_CY : EXT_SLOW_CY);

    typedef struct packed {
        csp_state_type      st;
        logic [DLY_W-1:0]   dly;
        logic [2:0]         win;
        logic [3:0]         div;
        logic               ext_clk_en;
        logic               ext_mode;
        csp_fuse_type       fz;
        logic [31:0]        rdata;
    } csp_top_state_type;

    csp_top_state_type cur;
    csp_top_state_type next_cur;

    logic       div_tick;
    logic       div_level;
    logic [3:0] div_active;
    logic [9:0] idx;
    logic       aligned;
    logic       hit_pre;
    logic       hit_any;
    logic       wr_en;

    // Delay counter must hold the longest reset delay
    if (DLY_MAX >= (64'h1 << DLY_W)) begin : g_check
        $error("csp_top: DLY_W too small for reset delay");
    end

    // Reset delay length, loaded one short since the last count is zero
    function automatic logic [DLY_W-1:0] reset_delay(input csp_fuse_type f);
        int unsigned extra;
        extra = 0;
        if (f.clock_source_select_fuses == SEL_LFO) begin
            if (f.startup_time_fuses == START_FAST) begin
                extra = LFO_FAST_CY;
            end else if (f.startup_time_fuses != START_PLAIN) begin
                extra = LFO_SLOW_CY;
            end
        end else begin
            if (f.startup_time_fuses == START_FAST) begin
                extra = EXT_FAST_CY;
            end else if (f.startup_time_fuses != START_PLAIN) begin
                extra = EXT_SLOW_CY;
            end
        end
        reset_delay = DLY_W'(RST_CK - 1 + extra);
    endfunction

    // Divided clock, count state kept private to the divider
    csp_divider #(
        .MAX_CODE    (8)
    ) u_divider (
        .pclk        (pclk),
        .presetn     (presetn),
        .div_code    (cur.div),
        .tick        (div_tick),
        .level       (div_level),
        .active_code (div_active)
    );

    // Address decode; the slave never inserts wait states
    assign idx     = paddr[11:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign hit_pre = aligned && (idx == IDX_PRESCALE);
    assign hit_any = aligned && ((idx == IDX_PRESCALE) || (idx == IDX_TIMER)
                                 || (idx == IDX_STATUS));
    assign wr_en   = psel && penable && pwrite && (cur.st != ST_SAMPLE);

    // Next state: sequencer, register writes and read capture
    always_comb begin
        next_cur = cur;

        // Unlock window counts raw clocks, so an interrupt between the
        // two writes would let it lapse; software keeps them masked
        if (cur.win != 3'h0) begin
            next_cur.win = cur.win - 3'h1;
        end

        // Reset delay and wake sequencer
        unique case (cur.st)
            ST_SAMPLE: begin
                next_cur.fz  = fuses;
                next_cur.div = fuses.divide_by_eight_fuse ? DIV_FUSE_RESET
                                                          : DIV_PLAIN_RESET;
                next_cur.dly = reset_delay(fuses);
                next_cur.st  = ST_DELAY;
            end
            ST_DELAY: begin
                if (cur.dly == '0) begin
                    next_cur.st = ST_RUN;
                end else begin
                    next_cur.dly = cur.dly - DLY_W'(1);
                end
            end
            ST_RUN: begin
                if (power_down) begin
                    next_cur.st = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (!power_down) begin
                    next_cur.st  = ST_WAKE;
                    next_cur.dly = DLY_W'(WAKE_CK - 1);
                end
            end
            ST_WAKE: begin
                if (cur.dly == '0) begin
                    next_cur.st = ST_RUN;
                end else begin
                    next_cur.dly = cur.dly - DLY_W'(1);
                end
            end
            default: begin
                next_cur.st = ST_SAMPLE;
            end
        endcase

        // Prescale writes: unlock alone, then division within the window
        if (wr_en && hit_pre) begin
            if (pwdata[7:0] == UNLOCK_VALUE) begin
                // A repeat unlock neither extends nor closes the window
                if (cur.win == 3'h0) begin
                    next_cur.win = UNLOCK_CYCLES;
                end
            end else if (!pwdata[PCE_BIT] && (cur.win != 3'h0)) begin
                next_cur.win = 3'h0;
                // Reserved codes close the window but keep the old factor
                if (pwdata[3:0] <= DIV_MAX) begin
                    next_cur.div = pwdata[3:0];
                end
            end
        end

        // Timer oscillator external clock enable
        if (wr_en && aligned && (idx == IDX_TIMER)) begin
            next_cur.ext_clk_en = pwdata[EXT_CLK_BIT];
        end
        next_cur.ext_mode = next_cur.ext_clk_en
            && (next_cur.fz.clock_source_select_fuses == SEL_RC);

        // Read data captured in the setup cycle, held through access
        if (psel && !penable) begin
            next_cur.rdata = 32'h0000_0000;
            if (aligned && !pwrite) begin
                if (idx == IDX_PRESCALE) begin
                    next_cur.rdata[PCE_BIT] = (cur.win != 3'h0);
                    next_cur.rdata[3:0]     = cur.div;
                end else if (idx == IDX_TIMER) begin
                    next_cur.rdata[EXT_CLK_BIT] = cur.ext_clk_en;
                end else if (idx == IDX_STATUS) begin
                    next_cur.rdata[RUN_BIT]           = core_reset_n;
                    next_cur.rdata[BAD_BIT]           = source_invalid;
                    next_cur.rdata[ACT_LSB +: 4]      = div_active;
                    next_cur.rdata[SEL_LSB +: 4]      =
                        cur.fz.clock_source_select_fuses;
                    next_cur.rdata[START_LSB +: 2]    = cur.fz.startup_time_fuses;
                end
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // APB answers: zero wait, error on unmapped or unaligned address
    assign prdata  = cur.rdata;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit_any;

    // Core reset released only after the delay; clock gated in sleep
    assign core_reset_n = (cur.st == ST_RUN) || (cur.st == ST_SLEEP)
                          || (cur.st == ST_WAKE);
    assign sys_clk_tick = div_tick && (cur.st == ST_RUN);

    // Live fuse so the override holds even while reset is asserted
    assign clock_output_pin      = fuses.clock_output_fuse ? div_level
                                                           : io_pin_data;
    assign clock_output_pin_oe_n = fuses.clock_output_fuse ? 1'b0
                                                           : io_pin_oe_n;

    // Source decode from the sampled fuses
    assign source_is_lfo  = (cur.fz.clock_source_select_fuses == SEL_LFO);
    assign source_is_ext  = (cur.fz.clock_source_select_fuses == SEL_EXT);
    assign source_invalid = !source_is_lfo && !source_is_ext
                            && (cur.fz.clock_source_select_fuses != SEL_RC);
    assign timer_osc_usable         = (cur.fz.clock_source_select_fuses == SEL_RC);
    assign timer_osc_pin_a_ext_mode = cur.ext_mode;

    // Checks on the block's own behaviour
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic wr_unlock;
    logic wr_divide;
    assign wr_unlock = wr_en && hit_pre && (pwdata[7:0] == UNLOCK_VALUE);
    assign wr_divide = wr_en && hit_pre && !pwdata[PCE_BIT]
                       && (pwdata[7:0] != UNLOCK_VALUE);

    a_unlock_opens: assert property (
        wr_unlock && (cur.win == 3'h0) |=> cur.win == UNLOCK_CYCLES)
        else $error("unlock write did not open window");

    a_unlock_no_extend: assert property (
        wr_unlock && (cur.win != 3'h0) |=> cur.win == $past(cur.win) - 3'h1)
        else $error("repeat unlock changed the window");

    a_window_timeout: assert property (
        wr_unlock && (cur.win == 3'h0) ##1 !wr_divide [*4] |=> cur.win == 3'h0)
        else $error("window open past four cycles");

    a_divide_taken: assert property (
        wr_divide && (cur.win != 3'h0) && (pwdata[3:0] <= DIV_MAX)
        |=> (cur.div == $past(pwdata[3:0])) && (cur.win == 3'h0))
        else $error("division write in window not taken");

    a_divide_locked: assert property (
        wr_en && hit_pre && (cur.win == 3'h0) |=> $stable(cur.div))
        else $error("division changed without unlock");

    a_code_range: assert property (
        cur.st != ST_SAMPLE |-> cur.div <= DIV_MAX)
        else $error("reserved division code held");

    a_reset_code: assert property (
        cur.st == ST_SAMPLE |=> cur.div == (cur.fz.divide_by_eight_fuse
                                            ? DIV_FUSE_RESET : DIV_PLAIN_RESET))
        else $error("wrong division code after reset");

    a_wake_six: assert property (
        cur.st == ST_SLEEP && !power_down |=> (cur.st == ST_WAKE) [*6] ##1
                                             (cur.st == ST_RUN))
        else $error("wake did not take six clocks");

    a_delay_holds: assert property (
        cur.st == ST_DELAY && (cur.dly != '0) |=> cur.st == ST_DELAY && !core_reset_n)
        else $error("core reset released early");

    a_clock_pin: assert property (
        fuses.clock_output_fuse |-> !clock_output_pin_oe_n
                                    && (clock_output_pin == div_level))
        else $error("clock pin not driven with divided clock");

    // Sequencer, fuse, lock and pin checks
    a_delay_done: assert property (
        cur.st == ST_DELAY && (cur.dly == '0) |=> core_reset_n)
        else $error("core reset not released after delay");

    a_sample_once: assert property (
        cur.st != ST_SAMPLE |=> $stable(cur.fz))
        else $error("fuse copy changed after sampling");

    a_lock_refused: assert property (
        wr_en && hit_pre && pwdata[PCE_BIT] && (pwdata[6:0] != 7'h00)
        && (cur.win == 3'h0) |=> cur.win == 3'h0)
        else $error("enable set with other bits nonzero");

    a_ext_mode_rc: assert property (
        timer_osc_pin_a_ext_mode |-> timer_osc_usable)
        else $error("timer pin clock mode without RC source");

    a_pin_follows_io: assert property (
        !fuses.clock_output_fuse |-> (clock_output_pin == io_pin_data)
                                     && (clock_output_pin_oe_n == io_pin_oe_n))
        else $error("clock pin not given back to port");

    c_change: cover property (wr_unlock ##[1:4] wr_divide);
    c_wake:   cover property (cur.st == ST_WAKE ##1 cur.st == ST_RUN);
    c_run:    cover property ($rose(core_reset_n));
    c_late:   cover property (wr_unlock ##5 wr_divide);
    c_resvd:  cover property (wr_divide && (cur.win != 3'h0) && (pwdata[3:0] > DIV_MAX));
endmodule // csp_top

/* File: csp_pkg.sv */
// Constants and types shared by the clock select and prescaler block
package csp_pkg;
    // Source clock rate
    localparam int unsigned CLK_MHZ = 20;

    // Clock source select codes
    localparam logic [3:0] SEL_EXT = 4'h0;
    localparam logic [3:0] SEL_RC  = 4'h2;
    localparam logic [3:0] SEL_LFO = 4'h3;

    // Start-up time codes
    localparam logic [1:0] START_PLAIN = 2'h0;
    localparam logic [1:0] START_FAST  = 2'h1;
    localparam logic [1:0] START_SLOW  = 2'h2;

    // Start-up and reset delay figures, clocks and microseconds
    localparam int unsigned WAKE_CK     = 6;
    localparam int unsigned RST_CK      = 14;
    localparam int unsigned LFO_FAST_US = 4000;
    localparam int unsigned LFO_SLOW_US = 64000;
    localparam int unsigned EXT_FAST_US = 4100;
    localparam int unsigned EXT_SLOW_US = 65000;

    // Register indices; the byte address is four times the index
    localparam logic [9:0] IDX_PRESCALE = 10'h061;
    localparam logic [9:0] IDX_TIMER    = 10'h062;
    localparam logic [9:0] IDX_STATUS   = 10'h063;

    // Prescale register fields and values
    localparam int unsigned PCE_BIT         = 7;
    localparam logic [7:0]  UNLOCK_VALUE    = 8'h80;
    localparam logic [2:0]  UNLOCK_CYCLES   = 3'h4;
    localparam logic [3:0]  DIV_MAX         = 4'h8;
    localparam logic [3:0]  DIV_FUSE_RESET  = 4'h3;
    localparam logic [3:0]  DIV_PLAIN_RESET = 4'h0;

    // Timer control and status fields
    localparam int unsigned EXT_CLK_BIT = 0;
    localparam int unsigned RUN_BIT     = 0;
    localparam int unsigned BAD_BIT     = 1;
    localparam int unsigned ACT_LSB     = 4;
    localparam int unsigned SEL_LSB     = 8;
    localparam int unsigned START_LSB   = 12;

    // Reset and wake sequencer states
    typedef enum logic [2:0] {
        ST_SAMPLE = 3'h0,
        ST_DELAY  = 3'h1,
        ST_RUN    = 3'h3,
        ST_SLEEP  = 3'h2,
        ST_WAKE   = 3'h6
    } csp_state_type;

    // Static configuration fuses
    typedef struct packed {
        logic [3:0] clock_source_select_fuses;
        logic [1:0] startup_time_fuses;
        logic       clock_output_fuse;
        logic       divide_by_eight_fuse;
    } csp_fuse_type;
endpackage

/* File: csp_divider.sv */
// Glitch-free system clock divider
`timescale 1ns/1ns
module csp_divider
    import csp_pkg::*;
#(
    parameter int unsigned MAX_CODE = 8
) (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Requested division code
    input  wire logic [3:0] div_code,
    // Divided clock
    output logic            tick,
    output logic            level,
    output logic [3:0]      active_code
);
    typedef struct packed {
        logic [7:0] cnt;
        logic [3:0] code;
        logic       tick;
        logic       level;
    } csp_div_state_type;

    csp_div_state_type cur;
    csp_div_state_type next_cur;

    // Counter cannot hold a longer period
    if (MAX_CODE > 8) begin : g_check
        $error("csp_divider: MAX_CODE above 8");
    end

    function automatic logic [7:0] period_minus_one(input logic [3:0] code);
        period_minus_one = 8'((9'h001 << code) - 9'h001);
    endfunction

    // New code only taken at a period end, so no short period appears
    always_comb begin
        next_cur = cur;
        next_cur.tick = 1'b0;
        if (cur.cnt == 8'h00) begin
            next_cur.tick  = 1'b1;
            next_cur.level = ~cur.level;
            next_cur.code  = div_code;
            next_cur.cnt   = period_minus_one(div_code);
        end else begin
            next_cur.cnt = cur.cnt - 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign tick        = cur.tick;
    assign level       = cur.level;
    assign active_code = cur.code;

    // Switch of factor only at a period boundary
    a_code_switch: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(cur.code) |-> cur.tick)
        else $error("division changed inside a period");
endmodule // csp_divider

/* File: csp_ext_clock_src.sv */
// External clock source model feeding the block's clock input
`timescale 1ns/1ns
module csp_ext_clock_src #(
    parameter int unsigned HALF_NS = 25
) (
    // Source clock
    output logic pclk
);
    // Fixed period, never stepped, so cycle-to-cycle drift stays far under the limit
    initial begin
        pclk = 1'b0;
        forever begin
            #(HALF_NS) pclk = ~pclk;
        end
    end
endmodule // csp_ext_clock_src

/* File: tb_clock_select_and_prescaler.sv */
// Self-checking testbench for the clock select and prescaler block
`timescale 1ns/1ns
module tb_clock_select_and_prescaler
    import csp_pkg::*;
();
    localparam logic [11:0] A_PRE = {IDX_PRESCALE, 2'b00};
    localparam logic [11:0] A_TMR = {IDX_TIMER, 2'b00};
    localparam logic [11:0] A_STS = {IDX_STATUS, 2'b00};
    localparam logic [11:0] A_BAD = 12'h0190;

    logic         pclk;
    logic         presetn;
    logic [11:0]  paddr;
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic [31:0]  pwdata;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    csp_fuse_type fuses;
    logic         power_down;
    logic         io_pin_data;
    logic         io_pin_oe_n;
    logic         clock_output_pin;
    logic         clock_output_pin_oe_n;
    logic         sys_clk_tick;
    logic         core_reset_n;
    logic         source_is_lfo;
    logic         source_is_ext;
    logic         source_invalid;
    logic         timer_osc_usable;
    logic         timer_osc_pin_a_ext_mode;
    int           miscompares;
    int           n_tests;

    // Clock comes from the far-side model
    csp_ext_clock_src ext_u (.pclk(pclk));

    // Delay counts shortened so every boot stays short
    csp_top #(.LFO_FAST_CY(20), .LFO_SLOW_CY(40), .EXT_FAST_CY(22), .EXT_SLOW_CY(44)) dut_u (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fuses(fuses), .power_down(power_down),
        .io_pin_data(io_pin_data), .io_pin_oe_n(io_pin_oe_n),
        .clock_output_pin(clock_output_pin), .clock_output_pin_oe_n(clock_output_pin_oe_n),
        .sys_clk_tick(sys_clk_tick), .core_reset_n(core_reset_n),
        .source_is_lfo(source_is_lfo), .source_is_ext(source_is_ext),
        .source_invalid(source_invalid), .timer_osc_usable(timer_osc_usable),
        .timer_osc_pin_a_ext_mode(timer_osc_pin_a_ext_mode));

    task automatic test_done();
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; returns at the edge where pready is sampled
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) miscompares++;
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b1, d, r, e);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b0, 32'h0000_0000, r, e);
        chk(r, exp);
    endtask

    // Cycles until the next tick, or the next change of the clock pin
    task automatic next_event(input logic pin, output int n);
        logic prev;
        prev = clock_output_pin;
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while ((pin ? clock_output_pin === prev : sys_clk_tick !== 1'b1) && n < 1000);
    endtask

    task automatic period_chk(input logic pin, input int exp);
        int n;
        next_event(pin, n);
        next_event(pin, n);
        chk(32'(n), 32'(exp));
    endtask

    // Reset for four cycles, then count edges until the core leaves reset
    task automatic do_reset(input csp_fuse_type f, input int edges);
        int n;
        @(posedge pclk);
        fuses <= f;
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        chk(clock_output_pin_oe_n, f.clock_output_fuse ? 1'b0 : io_pin_oe_n);
        presetn <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (core_reset_n !== 1'b1 && n < 200);
        chk(32'(n), 32'(edges));
    endtask

    task automatic test_boot_ext();
        logic [31:0] r;
        logic        e;
        do_reset(csp_fuse_type'{4'h0, 2'h1, 1'b1, 1'b1}, 37);
        chk(source_is_ext, 1'b1);
        chk(source_is_lfo, 1'b0);
        chk(source_invalid, 1'b0);
        rd_chk(A_STS, 32'h0000_1031);
        rd_chk(A_PRE, 32'h0000_0003);
        // Unmapped address reads zero with an error response
        apb(A_BAD, 1'b0, 32'h0000_0000, r, e);
        chk(r, 32'h0000_0000);
        chk(e, 1'b1);
        period_chk(1'b0, 8);
        period_chk(1'b1, 8);
        // Fuse inputs moved after boot must not matter
        @(posedge pclk);
        fuses.clock_source_select_fuses <= 4'h3;
        @(posedge pclk);
        #1;
        chk(source_is_ext, 1'b1);
        wr(A_TMR, 32'h0000_0001);
        #1;
        chk(timer_osc_pin_a_ext_mode, 1'b0);
        $display("boot_ext done");
    endtask

    task automatic test_unlock();
        int t1;
        int t2;
        int t3;
        // Back-to-back writes, as software does with interrupts masked
        wr(A_PRE, 32'h0000_0080);
        wr(A_PRE, 32'h0000_0001);
        next_event(1'b0, t1);
        next_event(1'b0, t2);
        next_event(1'b0, t3);
        chk(32'(t1 + t2 <= 8 + 2 * 2), 32'h0000_0001);
        chk(32'(t2 >= 2), 32'h0000_0001);
        chk(32'(t3), 32'h0000_0002);
        rd_chk(A_PRE, 32'h0000_0001);
        // Reserved code leaves the factor alone
        wr(A_PRE, 32'h0000_0080);
        wr(A_PRE, 32'h0000_0009);
        rd_chk(A_PRE, 32'h0000_0001);
        wr(A_PRE, 32'h0000_0080);
        wr(A_PRE, 32'h0000_0008);
        rd_chk(A_PRE, 32'h0000_0008);
        period_chk(1'b0, 256);
        $display("unlock done");
    endtask

    task automatic test_refused();
        wr(A_PRE, 32'h0000_0002);
        rd_chk(A_PRE, 32'h0000_0008);
        wr(A_PRE, 32'h0000_0081);
        wr(A_PRE, 32'h0000_0002);
        rd_chk(A_PRE, 32'h0000_0008);
        // Second unlock must not stretch the window past four cycles
        wr(A_PRE, 32'h0000_0080);
        wr(A_PRE, 32'h0000_0080);
        @(posedge pclk);
        wr(A_PRE, 32'h0000_0002);
        rd_chk(A_PRE, 32'h0000_0008);
        $display("refused done");
    endtask

    task automatic test_lfo();
        int n;
        @(posedge pclk);
        io_pin_data <= 1'b1;
        io_pin_oe_n <= 1'b1;
        do_reset(csp_fuse_type'{4'h3, 2'h2, 1'b0, 1'b0}, 55);
        chk(source_is_lfo, 1'b1);
        chk(clock_output_pin_oe_n, 1'b1);
        chk(clock_output_pin, 1'b1);
        rd_chk(A_PRE, 32'h0000_0000);
        period_chk(1'b0, 1);
        @(posedge pclk);
        power_down <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            #1;
            chk(sys_clk_tick, 1'b0);
        end
        @(posedge pclk);
        power_down <= 1'b0;
        next_event(1'b0, n);
        chk(32'(n >= 7 && n <= 8), 32'h0000_0001);
        chk(core_reset_n, 1'b1);
        $display("lfo done");
    endtask

    task automatic test_rc();
        do_reset(csp_fuse_type'{4'h2, 2'h0, 1'b0, 1'b0}, 15);
        chk(timer_osc_usable, 1'b1);
        wr(A_TMR, 32'h0000_0001);
        #1;
        chk(timer_osc_pin_a_ext_mode, 1'b1);
        rd_chk(A_TMR, 32'h0000_0001);
        $display("rc done");
    endtask

    // Main sequence
    initial begin
        miscompares = 0;
        n_tests = 0;
        presetn = 1'b0;
        paddr = 12'h000;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0000_0000;
        fuses = '0;
        power_down = 1'b0;
        io_pin_data = 1'b0;
        io_pin_oe_n = 1'b1;
        test_boot_ext();
        test_unlock();
        test_refused();
        test_lfo();
        test_rc();
        test_done();
    end

    // Watchdog well beyond the expected run of under a thousand cycles
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        test_done();
    end
endmodule // tb_clock_select_and_prescaler
